/* File: hw/obd_opt_pkg.sv */
package obd_opt_pkg;
  // register byte offsets
  localparam logic [7:0] off_cmd = 8'h00;
  localparam logic [7:0] off_arg_lo = 8'h04;
  localparam logic [7:0] off_arg_hi = 8'h08;
  localparam logic [7:0] off_status = 8'h0c;
  localparam logic [7:0] off_fc_ident = 8'h10;
  localparam logic [7:0] off_fc_data_lo = 8'h14;
  localparam logic [7:0] off_fc_data_hi = 8'h18;
  localparam logic [7:0] off_options = 8'h1c;
  localparam logic [7:0] off_keywords = 8'h20;
  localparam logic [7:0] off_ident = 8'h24;
  localparam logic [7:0] off_search_cfg = 8'h28;
  localparam logic [7:0] off_link = 8'h2c;
  // command codes written to off_cmd
  typedef enum logic [4:0] {
    cmd_none = 5'h00,
    flow_ctrl_mode_cmd = 5'h01,
    flow_ctrl_ident11_cmd = 5'h02,
    flow_ctrl_ident29_cmd = 5'h03,
    flow_ctrl_payload_cmd = 5'h04,
    forget_events_cmd = 5'h05,
    show_headers_off_cmd = 5'h06,
    show_headers_cmd = 5'h07,
    identify_cmd = 5'h08,
    iso_rate_default_cmd = 5'h09,
    iso_rate_slow_cmd = 5'h0a,
    response_byte_never = 5'h0b,
    response_byte_auto = 5'h0c,
    response_byte_always = 5'h0d,
    response_value_from_tester = 5'h0e,
    response_value_from_header = 5'h0f,
    iso_init_target_cmd = 5'h10,
    reversed_order_format = 5'h11,
    native_order_format = 5'h12,
    keyword_report_cmd = 5'h13,
    keyword_check_off = 5'h14,
    keyword_check_on = 5'h15,
    defaults_cmd = 5'h16
  } cmd_t;
  // flow control modes
  localparam logic [1:0] fc_auto = 2'h0;
  localparam logic [1:0] fc_user_all = 2'h1;
  localparam logic [1:0] fc_user_data = 2'h2;
  // response byte policies
  localparam logic [1:0] ifr_never = 2'h0;
  localparam logic [1:0] ifr_auto = 2'h1;
  localparam logic [1:0] ifr_always = 2'h2;
  // reset values
  localparam logic [7:0] iso_target_rst = 8'h33;
  localparam logic [7:0] tester_src_rst = 8'hf1;
  localparam logic [7:0] can_filler = 8'h00;
  localparam logic [16:0] rate_fast = 17'd10400;
  localparam logic [16:0] rate_slow = 17'd9600;
  // search block config bits
  localparam int blk_fault_bit = 5;
  localparam int blk_lowv_bit = 4;
  // status field positions
  localparam int st_err = 0;
  localparam int st_done = 1;
  localparam int st_ident = 2;
  localparam int st_kw = 3;
  localparam int st_can_blocked = 4;
  localparam logic [31:0] ident_code = 32'h0000_0a5a; // arbitrary
  localparam int flow_ctrl_bytes = 5;
  typedef struct packed {
    logic [1:0] fc_mode;
    logic show_headers;
    logic length_digit;
    logic rate_slow_sel;
    logic [1:0] ifr_policy;
    logic ifr_from_tester;
    logic reverse_j1939;
    logic keyword_check;
  } opts_t;
  localparam opts_t opts_rst = '{fc_auto, 1'b0, 1'b0, 1'b0, ifr_auto, 1'b0, 1'b1, 1'b1};
endpackage

/* File: hw/obd_protocol_option_commands.sv */
`timescale 1ns/1ps
`default_nettype none
module obd_protocol_option_commands (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic can_search_fault_event,
  input wire logic low_voltage_restart_event,
  input wire logic first_frame_seen,
  input wire logic keyword_valid,
  input wire logic [7:0] keyword1,
  input wire logic [7:0] keyword2,
  input wire logic keyword_expected,
  input wire logic [7:0] header_source,
  input wire logic header_k_bit,
  input wire logic j1939_selected,
  input wire logic [1:0] tx_len,
  input wire logic [23:0] tx_data_in,
  output logic flow_ctrl_send,
  output logic can_search_blocked,
  output logic iso_init_fail,
  output logic keyword_ack,
  output logic response_byte_send,
  output logic [7:0] response_byte_value,
  output logic [23:0] tx_data_out,
  output logic [16:0] iso_rate,
  output logic iso_relaxed_timing,
  output logic [7:0] iso_target_addr,
  output logic show_headers
);
  ////////////////////////////////////////////////////////////////////
  obd_opt_pkg::opts_t opts_r;
  logic [28:0] fc_ident_r;
  logic [39:0] fc_data_r;
  logic [31:0] arg_lo_r;
  logic [7:0] arg_hi_r;
  logic [7:0] iso_target_r;
  logic [7:0] tester_src_r;
  logic [7:0] search_cfg_r;
  logic [15:0] kw_r;
  logic fault_seen_r;
  logic lowv_seen_r;
  logic err_r;
  logic done_r;
  logic ident_r;
  logic kw_rep_r;
  logic bus_ack;
  logic [39:0] payload_src;
  logic cmd_go;
  obd_opt_pkg::cmd_t cmd;

  // one wait state: request accepted on the second edge
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
    end
  end
  assign bus_ack = ~avs_waitrequest;
  assign cmd_go = bus_ack & avs_write & (avs_address == obd_opt_pkg::off_cmd) & avs_byteenable[0];
  // fifth payload byte carries only the low nibble of arg_hi
  assign payload_src = {4'h0, arg_hi_r[3:0], arg_lo_r};
  assign cmd = obd_opt_pkg::cmd_t'(avs_writedata[4:0]);

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // argument and config registers
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      arg_lo_r <= 32'h0000_0000;
      arg_hi_r <= 8'h00;
      tester_src_r <= obd_opt_pkg::tester_src_rst;
      search_cfg_r <= 8'h00;
    end else if (bus_ack & avs_write) begin
      if (avs_address == obd_opt_pkg::off_arg_lo) begin
        arg_lo_r <= merge(arg_lo_r, avs_writedata, avs_byteenable);
      end
      if (avs_address == obd_opt_pkg::off_arg_hi && avs_byteenable[0]) begin
        arg_hi_r <= avs_writedata[7:0];
      end
      if (avs_address == obd_opt_pkg::off_search_cfg && avs_byteenable[0]) begin
        search_cfg_r <= avs_writedata[7:0];
      end
      if (avs_address == obd_opt_pkg::off_link && avs_byteenable[0]) begin
        tester_src_r <= avs_writedata[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // command execution
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      opts_r <= obd_opt_pkg::opts_rst;
      fc_ident_r <= 29'h0;
      fc_data_r <= 40'h0;
      iso_target_r <= obd_opt_pkg::iso_target_rst;
      err_r <= 1'b0;
      done_r <= 1'b0;
      ident_r <= 1'b0;
      kw_rep_r <= 1'b0;
    end else if (cmd_go) begin
      err_r <= 1'b0;
      done_r <= 1'b1;
      ident_r <= 1'b0;
      kw_rep_r <= 1'b0;
      unique case (cmd)
        obd_opt_pkg::flow_ctrl_mode_cmd: begin
          if (arg_lo_r[1:0] == 2'h3 || arg_lo_r[31:2] != 30'h0) begin
            err_r <= 1'b1;
          end else begin
            opts_r.fc_mode <= arg_lo_r[1:0];
          end
        end
        obd_opt_pkg::flow_ctrl_ident11_cmd: fc_ident_r <= {18'h0, arg_lo_r[10:0]};
        obd_opt_pkg::flow_ctrl_ident29_cmd: fc_ident_r <= arg_lo_r[28:0];
        obd_opt_pkg::flow_ctrl_payload_cmd: begin
          if (arg_hi_r[7:4] == 4'h0 || arg_hi_r[7:4] > 4'(obd_opt_pkg::flow_ctrl_bytes)) begin
            err_r <= 1'b1;
          end else begin
            for (int i = 0; i < obd_opt_pkg::flow_ctrl_bytes; i++) begin
              if (i < int'(arg_hi_r[7:4])) begin
                fc_data_r[i*8 +: 8] <= payload_src[i*8 +: 8];
              end else begin
                fc_data_r[i*8 +: 8] <= obd_opt_pkg::can_filler;
              end
            end
          end
        end
        obd_opt_pkg::forget_events_cmd: ;
        obd_opt_pkg::show_headers_off_cmd: opts_r.show_headers <= 1'b0;
        obd_opt_pkg::show_headers_cmd: begin
          opts_r.show_headers <= 1'b1;
          opts_r.length_digit <= arg_lo_r[0];
        end
        obd_opt_pkg::identify_cmd: ident_r <= 1'b1;
        obd_opt_pkg::iso_rate_default_cmd: opts_r.rate_slow_sel <= 1'b0;
        obd_opt_pkg::iso_rate_slow_cmd: opts_r.rate_slow_sel <= 1'b1;
        obd_opt_pkg::response_byte_never: opts_r.ifr_policy <= obd_opt_pkg::ifr_never;
        obd_opt_pkg::response_byte_auto: opts_r.ifr_policy <= obd_opt_pkg::ifr_auto;
        obd_opt_pkg::response_byte_always: opts_r.ifr_policy <= obd_opt_pkg::ifr_always;
        obd_opt_pkg::response_value_from_tester: opts_r.ifr_from_tester <= 1'b1;
        obd_opt_pkg::response_value_from_header: opts_r.ifr_from_tester <= 1'b0;
        obd_opt_pkg::iso_init_target_cmd: iso_target_r <= arg_lo_r[7:0];
        obd_opt_pkg::reversed_order_format: opts_r.reverse_j1939 <= 1'b1;
        obd_opt_pkg::native_order_format: opts_r.reverse_j1939 <= 1'b0;
        obd_opt_pkg::keyword_report_cmd: kw_rep_r <= 1'b1;
        obd_opt_pkg::keyword_check_off: opts_r.keyword_check <= 1'b0;
        obd_opt_pkg::keyword_check_on: opts_r.keyword_check <= 1'b1;
        obd_opt_pkg::defaults_cmd: begin
          opts_r <= obd_opt_pkg::opts_rst;
          iso_target_r <= obd_opt_pkg::iso_target_rst;
        end
        default: err_r <= 1'b1;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // search blocking events; a new event whose search_cfg_r block bit is set wins over forget
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      fault_seen_r <= 1'b0;
      lowv_seen_r <= 1'b0;
    end else begin
      if (can_search_fault_event && search_cfg_r[obd_opt_pkg::blk_fault_bit]) begin
        fault_seen_r <= 1'b1;
      end else if (cmd_go && cmd == obd_opt_pkg::forget_events_cmd) begin
        fault_seen_r <= 1'b0;
      end
      if (low_voltage_restart_event && search_cfg_r[obd_opt_pkg::blk_lowv_bit]) begin
        lowv_seen_r <= 1'b1;
      end else if (cmd_go && cmd == obd_opt_pkg::forget_events_cmd) begin
        lowv_seen_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // link side outputs
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      kw_r <= 16'h0;
      keyword_ack <= 1'b0;
      iso_init_fail <= 1'b0;
      flow_ctrl_send <= 1'b0;
      response_byte_send <= 1'b0;
      response_byte_value <= 8'h00;
      tx_data_out <= 24'h0;
      can_search_blocked <= 1'b0;
      iso_rate <= obd_opt_pkg::rate_fast;
      iso_relaxed_timing <= 1'b0;
      iso_target_addr <= obd_opt_pkg::iso_target_rst;
      show_headers <= 1'b0;
    end else begin
      if (keyword_valid) begin
        kw_r <= {keyword1, keyword2};
      end
      keyword_ack <= keyword_valid;
      iso_init_fail <= keyword_valid & opts_r.keyword_check & ~keyword_expected;
      flow_ctrl_send <= first_frame_seen;
      unique case (opts_r.ifr_policy)
        obd_opt_pkg::ifr_never: response_byte_send <= 1'b0;
        obd_opt_pkg::ifr_always: response_byte_send <= 1'b1;
        default: response_byte_send <= ~header_k_bit;
      endcase
      response_byte_value <= opts_r.ifr_from_tester ? tester_src_r : header_source;
      if (opts_r.reverse_j1939 && j1939_selected && tx_len == 2'd3) begin
        tx_data_out <= {tx_data_in[7:0], tx_data_in[15:8], tx_data_in[23:16]};
      end else begin
        tx_data_out <= tx_data_in;
      end
      can_search_blocked <= fault_seen_r | lowv_seen_r;
      iso_rate <= opts_r.rate_slow_sel ? obd_opt_pkg::rate_slow : obd_opt_pkg::rate_fast;
      iso_relaxed_timing <= opts_r.rate_slow_sel;
      iso_target_addr <= iso_target_r;
      show_headers <= opts_r.show_headers;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // read data
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      avs_readdata <= 32'h0;
    end else if (avs_read & ~bus_ack) begin
      unique case (avs_address)
        obd_opt_pkg::off_arg_lo: avs_readdata <= arg_lo_r;
        obd_opt_pkg::off_arg_hi: avs_readdata <= {24'h0, arg_hi_r};
        obd_opt_pkg::off_status: avs_readdata <= {27'h0, fault_seen_r | lowv_seen_r, kw_rep_r,
                                                  ident_r, done_r, err_r};
        obd_opt_pkg::off_fc_ident: avs_readdata <= {3'h0, fc_ident_r};
        obd_opt_pkg::off_fc_data_lo: avs_readdata <= fc_data_r[31:0];
        obd_opt_pkg::off_fc_data_hi: avs_readdata <= {24'h0, fc_data_r[39:32]};
        obd_opt_pkg::off_options: avs_readdata <= {14'h0, iso_target_r, 10'(opts_r)};
        obd_opt_pkg::off_keywords: avs_readdata <= {16'h0, kw_r};
        obd_opt_pkg::off_ident: avs_readdata <= obd_opt_pkg::ident_code;
        obd_opt_pkg::off_search_cfg: avs_readdata <= {24'h0, search_cfg_r};
        obd_opt_pkg::off_link: avs_readdata <= {24'h0, tester_src_r};
        default: avs_readdata <= 32'h0;
      endcase
    end
  end
endmodule // obd_protocol_option_commands
`default_nettype wire

/* File: verification/ecu_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ecu_model (
  input wire logic clock,
  input wire logic keyword_ack,
  input wire logic flow_ctrl_send,
  output logic first_frame_seen,
  output logic keyword_valid,
  output logic [7:0] keyword1,
  output logic [7:0] keyword2,
  output logic keyword_expected,
  output logic [7:0] header_source,
  output logic header_k_bit
);
  int acks = 0;
  int flows = 0;
  logic [15:0] kw_r = 16'h0000;
  logic [7:0] junk = 8'h00;
  // key word lines carry noise outside the valid pulse
  assign keyword1 = keyword_valid ? kw_r[15:8] : junk;
  assign keyword2 = keyword_valid ? kw_r[7:0] : ~junk;
  initial begin
    first_frame_seen = 1'b0;
    keyword_valid = 1'b0;
    keyword_expected = 1'b0;
    header_source = 8'h00;
    header_k_bit = 1'b1;
  end
  always @(posedge clock) begin
    junk <= junk + 8'h01;
    acks <= acks + int'(keyword_ack);
    flows <= flows + int'(flow_ctrl_send);
  end
  task automatic frame();
    @(posedge clock) first_frame_seen <= 1'b1;
    @(posedge clock) first_frame_seen <= 1'b0;
  endtask
  task automatic keywords(input logic [7:0] k1, input logic [7:0] k2, input logic ok);
    @(posedge clock);
    kw_r <= {k1, k2};
    keyword_expected <= ok;
    keyword_valid <= 1'b1;
    @(posedge clock) keyword_valid <= 1'b0;
  endtask
  task automatic header(input logic [7:0] src, input logic k);
    @(posedge clock);
    header_source <= src;
    header_k_bit <= k;
  endtask
endmodule // ecu_model
`default_nettype wire

/* File: verification/obd_opt_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module obd_opt_asserts (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic can_search_fault_event,
  input wire logic low_voltage_restart_event,
  input wire logic first_frame_seen,
  input wire logic keyword_valid,
  input wire logic keyword_expected,
  input wire logic flow_ctrl_send,
  input wire logic can_search_blocked,
  input wire logic iso_init_fail,
  input wire logic keyword_ack,
  input wire logic [16:0] iso_rate,
  input wire logic iso_relaxed_timing,
  input wire logic [7:0] iso_target_addr
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  flow_reply_a: assert property (flow_ctrl_send == $past(first_frame_seen))
    else $error("flow control pulse not tied to first frame");
  kw_ack_a: assert property (keyword_valid |=> keyword_ack)
    else $error("key words not acknowledged");
  ack_cause_a: assert property (keyword_ack |-> $past(keyword_valid))
    else $error("acknowledge without key words");
  kw_pass_a: assert property (keyword_valid && keyword_expected |=> !iso_init_fail)
    else $error("init failed on good key words");
  fail_cause_a: assert property (iso_init_fail |-> $past(keyword_valid && !keyword_expected))
    else $error("init fail without bad key words");
  wait_once_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  wait_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |-> ##1 !avs_waitrequest)
    else $error("request not answered after one wait state");
  block_cause_a: assert property ($rose(can_search_blocked) |->
    $past(can_search_fault_event || low_voltage_restart_event, 2))
    else $error("search blocked without an event");
  rate_pair_a: assert property ((iso_rate == 17'd10400 && !iso_relaxed_timing) ||
    (iso_rate == 17'd9600 && iso_relaxed_timing))
    else $error("iso rate and relaxed timing disagree");
  target_hold_a: assert property ($changed(iso_target_addr) |->
    $past(avs_write) || $past(avs_write, 2))
    else $error("init target changed without a write");
endmodule // obd_opt_asserts
////////////////////////////////////////////////////////////////
bind obd_protocol_option_commands obd_opt_asserts i_chk (.clock, .sys_rst, .avs_read,
  .avs_write, .avs_waitrequest, .can_search_fault_event, .low_voltage_restart_event,
  .first_frame_seen, .keyword_valid, .keyword_expected, .flow_ctrl_send, .can_search_blocked,
  .iso_init_fail, .keyword_ack, .iso_rate, .iso_relaxed_timing, .iso_target_addr);
`default_nettype wire

/* File: verification/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clock = 0, sys_rst = 1, avs_read = 0, avs_write = 0, avs_waitrequest;
  logic [7:0] avs_address = 8'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  logic [3:0] avs_byteenable = 4'hf;
  logic can_search_fault_event = 0, low_voltage_restart_event = 0, j1939_selected = 0;
  logic [1:0] tx_len = 2'h0;
  logic [23:0] tx_data_in = 24'h0, tx_data_out;
  logic first_frame_seen, keyword_valid, keyword_expected, header_k_bit, flow_ctrl_send;
  logic [7:0] keyword1, keyword2, header_source, response_byte_value, iso_target_addr;
  logic can_search_blocked, iso_init_fail, keyword_ack, response_byte_send;
  logic iso_relaxed_timing, show_headers;
  logic [16:0] iso_rate;
  int err_count = 0, checks_done = 0, fails = 0, a0, f0;
  always #5 clock = ~clock;
  always @(posedge clock) fails <= fails + int'(iso_init_fail);
  obd_protocol_option_commands i_dut (.clock, .sys_rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .can_search_fault_event,
    .low_voltage_restart_event, .first_frame_seen, .keyword_valid, .keyword1, .keyword2,
    .keyword_expected, .header_source, .header_k_bit, .j1939_selected, .tx_len, .tx_data_in,
    .flow_ctrl_send, .can_search_blocked, .iso_init_fail, .keyword_ack, .response_byte_send,
    .response_byte_value, .tx_data_out, .iso_rate, .iso_relaxed_timing, .iso_target_addr,
    .show_headers);
  ecu_model i_ecu (.clock, .keyword_ack, .flow_ctrl_send, .first_frame_seen, .keyword_valid,
    .keyword1, .keyword2, .keyword_expected, .header_source, .header_k_bit);
  //////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] be = 4'hf);
    int n;
    n = 0;
    @(posedge clock);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 64);
    if (n >= 64) begin
      err_count++;
      $display("wrong value waitrequest expected 0 seen 1");
      give_verdict();
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic settle();
    repeat (2) @(posedge clock);
    #1;
  endtask
  task automatic cmd(input logic [4:0] c, input logic [31:0] arg);
    bus(1'b1, obd_opt_pkg::off_arg_lo, arg);
    bus(1'b1, obd_opt_pkg::off_cmd, {27'h0, c});
    settle();
  endtask
  task automatic tx(input logic s, input logic [1:0] n, input logic [23:0] d, input logic [23:0] e);
    @(posedge clock);
    j1939_selected <= s;
    tx_len <= n;
    tx_data_in <= d;
    settle();
    chk("tx data", e, tx_data_out);
  endtask
  //////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clock);
    chk("rate", obd_opt_pkg::rate_fast, iso_rate);
    chk("target", obd_opt_pkg::iso_target_rst, iso_target_addr);
    chk("headers", 0, show_headers);
    sys_rst <= 1'b0;
    bus(0, obd_opt_pkg::off_options, 0);
    chk("options", {14'h0, obd_opt_pkg::iso_target_rst, obd_opt_pkg::opts_rst}, rd);
    bus(0, obd_opt_pkg::off_link, 0);
    chk("tester", {24'h0, obd_opt_pkg::tester_src_rst}, rd);
    bus(0, obd_opt_pkg::off_ident, 0);
    chk("ident", obd_opt_pkg::ident_code, rd);
    bus(0, 8'h40, 32'h1);
    chk("unmapped", 0, rd);
    $display("test reset done");
    for (int m = 0; m < 4; m++) begin
      cmd(obd_opt_pkg::flow_ctrl_mode_cmd, m);
      bus(0, obd_opt_pkg::off_options, 0);
      chk("fc mode", (m < 3) ? m : 2, rd[9:8]);
      bus(0, obd_opt_pkg::off_status, 0);
      chk("fc err", m == 3, rd[obd_opt_pkg::st_err]);
    end
    cmd(obd_opt_pkg::flow_ctrl_ident11_cmd, 32'h0000_0fff);
    bus(0, obd_opt_pkg::off_fc_ident, 0);
    chk("fc id11", 32'h0000_07ff, rd);
    bus(1, obd_opt_pkg::off_arg_lo, 32'hffff_ffff);
    bus(1, obd_opt_pkg::off_arg_lo, 32'h0, 4'h3);
    bus(1, obd_opt_pkg::off_cmd, {27'h0, obd_opt_pkg::flow_ctrl_ident29_cmd});
    bus(0, obd_opt_pkg::off_fc_ident, 0);
    chk("fc id29", 32'h1fff_0000, rd);
    for (int n = 0; n < 7; n += 3) begin
      bus(1, obd_opt_pkg::off_arg_hi, n << 4);
      cmd(obd_opt_pkg::flow_ctrl_payload_cmd, 32'h4433_2211);
      bus(0, obd_opt_pkg::off_status, 0);
      chk("payload err", n != 3, rd[obd_opt_pkg::st_err]);
      bus(0, obd_opt_pkg::off_fc_data_lo, 0);
      chk("payload lo", (n < 3) ? 32'h0 : {obd_opt_pkg::can_filler, 24'h33_2211}, rd);
    end
    bus(0, obd_opt_pkg::off_fc_data_hi, 0);
    chk("payload hi", {24'h0, obd_opt_pkg::can_filler}, rd);
    $display("test flow control done");
    for (int i = 0; i < 4; i++) begin
      bus(1, obd_opt_pkg::off_search_cfg, (i == 0 || i == 3) ? 32'h20 : 32'h10);
      @(posedge clock);
      can_search_fault_event <= !i[0];
      low_voltage_restart_event <= i[0];
      @(posedge clock);
      can_search_fault_event <= 1'b0;
      low_voltage_restart_event <= 1'b0;
      settle();
      chk("blocked", i < 2, can_search_blocked);
      cmd(obd_opt_pkg::forget_events_cmd, 0);
      chk("forgotten", 0, can_search_blocked);
    end
    $display("test events done");
    cmd(obd_opt_pkg::show_headers_cmd, 1);
    chk("hdr on", 1, show_headers);
    bus(0, obd_opt_pkg::off_options, 0);
    chk("len digit", 1, rd[6]);
    cmd(obd_opt_pkg::show_headers_off_cmd, 0);
    chk("hdr off", 0, show_headers);
    cmd(obd_opt_pkg::show_headers_cmd, 0);
    chk("hdr on again", 1, show_headers);
    cmd(obd_opt_pkg::iso_rate_slow_cmd, 0);
    chk("slow", obd_opt_pkg::rate_slow, iso_rate);
    chk("relaxed", 1, iso_relaxed_timing);
    cmd(obd_opt_pkg::iso_rate_default_cmd, 0);
    chk("fast", obd_opt_pkg::rate_fast, iso_rate);
    for (int p = 0; p < 6; p++) begin
      cmd(5'(obd_opt_pkg::response_byte_never + p / 2), 0);
      i_ecu.header(8'h5c, p[0]);
      settle();
      chk("ifr send", p / 2 == 2 || (p / 2 == 1 && !p[0]), response_byte_send);
    end
    chk("ifr value", 8'h5c, response_byte_value);
    cmd(obd_opt_pkg::response_value_from_tester, 0);
    chk("ifr tester", obd_opt_pkg::tester_src_rst, response_byte_value);
    $display("test options done");
    cmd(obd_opt_pkg::iso_init_target_cmd, 32'h0000_007a);
    chk("target", 8'h7a, iso_target_addr);
    cmd(obd_opt_pkg::identify_cmd, 0);
    bus(0, obd_opt_pkg::off_status, 0);
    chk("ident shown", 1, rd[obd_opt_pkg::st_ident]);
    chk("target kept", 8'h7a, iso_target_addr);
    cmd(obd_opt_pkg::defaults_cmd, 0);
    chk("target restored", 8'h33, iso_target_addr);
    tx(1, 2'd3, 24'h00feee, 24'heefe00);
    tx(1, 2'd2, 24'h00feee, 24'h00feee);
    tx(0, 2'd3, 24'h00feee, 24'h00feee);
    cmd(obd_opt_pkg::native_order_format, 0);
    tx(1, 2'd3, 24'h00feee, 24'h00feee);
    $display("test target and j1939 done");
    for (int c = 0; c < 3; c++) begin
      cmd(c == 0 ? obd_opt_pkg::keyword_check_off : obd_opt_pkg::keyword_check_on, 0);
      a0 = i_ecu.acks;
      f0 = fails;
      i_ecu.keywords(8'h08, 8'h94, c == 2);
      repeat (3) @(posedge clock);
      #1;
      chk("kw ack", a0 + 1, i_ecu.acks);
      chk("kw fail", f0 + (c == 1), fails);
    end
    bus(0, obd_opt_pkg::off_keywords, 0);
    chk("keywords", 32'h0000_0894, rd);
    cmd(obd_opt_pkg::keyword_report_cmd, 0);
    bus(0, obd_opt_pkg::off_status, 0);
    chk("kw report", 1, rd[obd_opt_pkg::st_kw]);
    a0 = i_ecu.flows;
    i_ecu.frame();
    repeat (3) @(posedge clock);
    #1;
    chk("flow sent", a0 + 1, i_ecu.flows);
    $display("test ecu side done");
    give_verdict();
  end
  initial begin
    repeat (100000) @(posedge clock);
    err_count++;
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
